// File: verilog/flash_disk_host_window.sv
// host controller for a memory-mapped flash disk window
// assumes the device pins are wired straight to these ports and
// that i_data and i_busy_n are already synchronous to i_mclk
`include "flash_host_params.svh"

module flash_disk_host_window #(
    parameter int BOOT_TIMEOUT_CYC = `BOOT_LOAD_US * `CLK_MHZ
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    // user side
    input wire logic i_reinit,
    input wire logic i_req_valid,
    input wire flash_host_pkg::host_req_type i_req,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [`WIN_DATA_W-1:0] o_rsp_data,
    output logic o_init_fault,
    // device side
    output logic [`WIN_ADDR_W-1:0] o_addr,
    input wire logic [`WIN_DATA_W-1:0] i_data,
    output logic [`WIN_DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_reset_in_n,
    output logic [1:0] o_cascade_slot,
    input wire logic i_busy_n
);

    // ----------------------------------------------------------------
    // phase lengths
    // ----------------------------------------------------------------
    localparam logic [`TMR_W-1:0] RST_CYC =
        flash_host_pkg::ns_to_cyc(`RST_HOLD_NS);
    localparam logic [`TMR_W-1:0] SETUP_CYC =
        flash_host_pkg::ns_to_cyc(`ADDR_SETUP_NS);
    localparam logic [`TMR_W-1:0] STROBE_CYC =
        flash_host_pkg::ns_to_cyc(`STROBE_NS);
    localparam logic [`TMR_W-1:0] HOLD_CYC =
        flash_host_pkg::ns_to_cyc(`DATA_HOLD_NS);
    localparam logic [`TMR_W-1:0] BOOT_CYC = `TMR_W'(BOOT_TIMEOUT_CYC);

    flash_host_pkg::host_regs_type regs_r;
    flash_host_pkg::host_regs_type regs_nxt;
    logic tmr_load;
    logic [`TMR_W-1:0] tmr_count;
    logic tmr_last;
    logic accept;

    // ----------------------------------------------------------------
    // phase timer
    // ----------------------------------------------------------------
    flash_host_timer u_timer (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_last(tmr_last)
    );

    // no access is started while the device reports busy
    assign accept = (regs_r.st == flash_host_pkg::ST_IDLE) && i_busy_n
        && i_req_valid && !i_reinit;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.done = 1'b0;
        tmr_load = 1'b0;
        tmr_count = SETUP_CYC;
        case (regs_r.st)
            flash_host_pkg::ST_RESET: begin
                // hold the device reset low, then let it load
                if (tmr_last) begin
                    regs_nxt.rst_n = 1'b1;
                    regs_nxt.st = flash_host_pkg::ST_LOAD_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = BOOT_CYC;
                end
            end
            flash_host_pkg::ST_LOAD_WAIT: begin
                // busy stays low until the boot download ends
                if (i_busy_n) begin
                    regs_nxt.st = flash_host_pkg::ST_IDLE;
                end else if (tmr_last) begin
                    regs_nxt.fault = 1'b1;
                    regs_nxt.st = flash_host_pkg::ST_IDLE;
                end
            end
            flash_host_pkg::ST_IDLE: begin
                if (i_reinit) begin
                    regs_nxt.rst_n = 1'b0;
                    regs_nxt.fault = 1'b0;
                    regs_nxt.st = flash_host_pkg::ST_RESET;
                    tmr_load = 1'b1;
                    tmr_count = RST_CYC;
                end else if (accept) begin
                    regs_nxt.is_write = i_req.write;
                    regs_nxt.addr = i_req.addr;
                    regs_nxt.wdata = i_req.wdata;
                    regs_nxt.st = flash_host_pkg::ST_SETUP;
                    tmr_load = 1'b1;
                    tmr_count = SETUP_CYC;
                end
            end
            flash_host_pkg::ST_SETUP: begin
                if (tmr_last) begin
                    regs_nxt.st = flash_host_pkg::ST_STROBE;
                    tmr_load = 1'b1;
                    tmr_count = STROBE_CYC;
                end
            end
            flash_host_pkg::ST_STROBE: begin
                if (tmr_last) begin
                    if (!regs_r.is_write) begin
                        regs_nxt.rdata = i_data;
                    end
                    regs_nxt.done = 1'b1;
                    regs_nxt.st = flash_host_pkg::ST_HOLD;
                    tmr_load = 1'b1;
                    tmr_count = HOLD_CYC;
                end
            end
            flash_host_pkg::ST_HOLD: begin
                if (tmr_last) begin
                    regs_nxt.st = flash_host_pkg::ST_IDLE;
                end
            end
            default: begin
                regs_nxt.st = flash_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            regs_r.st <= flash_host_pkg::ST_RESET;
            regs_r.is_write <= 1'b0;
            regs_r.addr <= `ADDR_RST;
            regs_r.wdata <= `BYTE_RST;
            regs_r.rdata <= `BYTE_RST;
            regs_r.done <= 1'b0;
            regs_r.fault <= 1'b0;
            regs_r.rst_n <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // chip select spans setup, strobe and hold; one strobe at a time
    assign o_ce_n = !((regs_r.st == flash_host_pkg::ST_SETUP)
        || (regs_r.st == flash_host_pkg::ST_STROBE)
        || (regs_r.st == flash_host_pkg::ST_HOLD));
    assign o_oe_n = !((regs_r.st == flash_host_pkg::ST_STROBE)
        && !regs_r.is_write);
    assign o_we_n = !((regs_r.st == flash_host_pkg::ST_STROBE)
        && regs_r.is_write);
    // host drives data only on writes, never while oe is low, and
    // frees the shared lines outside chip select
    assign o_data_oe = regs_r.is_write && !o_ce_n;
    assign o_data = regs_r.wdata;
    assign o_addr = regs_r.addr;
    assign o_reset_in_n = regs_r.rst_n;
    // one device on the window takes slot zero
    assign o_cascade_slot = `SLOT_SINGLE;

    // ----------------------------------------------------------------
    // user side
    // ----------------------------------------------------------------
    assign o_req_ready = (regs_r.st == flash_host_pkg::ST_IDLE) && i_busy_n
        && !i_reinit;
    assign o_rsp_valid = regs_r.done;
    assign o_rsp_data = regs_r.rdata;
    assign o_init_fault = regs_r.fault;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence read_strobe_s;
        $fell(o_oe_n) ##0 !o_ce_n ##1 !o_oe_n [*2] ##1 o_oe_n;
    endsequence

    sequence write_strobe_s;
        $fell(o_we_n) ##1 !o_we_n [*2] ##1 o_we_n;
    endsequence

    chk_access_not_busy: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_ce_n) |-> $past(i_busy_n))
        else $error("access started while device busy");

    chk_ready_after_release: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_reset_in_n) |-> !o_req_ready)
        else $error("ready given at reset release");

    chk_strobes_exclusive: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !(!o_oe_n && !o_we_n))
        else $error("read and write strobes both low");

    chk_strobe_in_select: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!o_oe_n || !o_we_n) |-> !o_ce_n ##1 !o_ce_n)
        else $error("strobe outside chip select");

    chk_read_capture: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        read_strobe_s |-> o_rsp_valid && o_rsp_data == $past(i_data))
        else $error("read byte not returned at strobe end");

    chk_write_drive: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        write_strobe_s |-> o_data_oe && o_oe_n && !o_ce_n)
        else $error("write data not held past strobe");

    chk_no_drive_on_read: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        !o_oe_n |-> !o_data_oe)
        else $error("host drives data during read");

    chk_slot_single: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        o_cascade_slot == `SLOT_SINGLE)
        else $error("cascade slot not zero");

    chk_reset_width: assert property (
        @(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_reset_in_n) |-> !o_reset_in_n [*5] ##1 o_reset_in_n)
        else $error("device reset pulse width wrong");

endmodule : flash_disk_host_window

// File: verilog/flash_host_params.svh
// constants for the flash disk host window controller
// assumes a 10 MHz i_mclk and one device on the window pins
//
// Functional notes
// - host uses chip select, read, write strobes
// - single device system straps slot to zero
// - cascaded devices share all bus pins
// - busy low while initializing; host waits
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define WIN_ADDR_W 13
`define WIN_DATA_W 8
`define TMR_W 14

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define CLK_MHZ 10
`define RST_HOLD_NS 500
`define ADDR_SETUP_NS 100
`define STROBE_NS 250
`define DATA_HOLD_NS 100
`define BOOT_LOAD_US 1000

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define SLOT_SINGLE 2'h0
`define ADDR_RST 13'h0000
`define BYTE_RST 8'h00

`endif

// File: verilog/flash_host_pkg.sv
// types shared by the flash disk host window controller
// assumes flash_host_params.svh is on the include path
`include "flash_host_params.svh"

package flash_host_pkg;

    // ----------------------------------------------------------------
    // request carried from the user side
    // ----------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [`WIN_ADDR_W-1:0] addr;
        logic [`WIN_DATA_W-1:0] wdata;
    } host_req_type;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_LOAD_WAIT,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } host_state_type;

    typedef struct packed {
        host_state_type st;
        logic is_write;
        logic [`WIN_ADDR_W-1:0] addr;
        logic [`WIN_DATA_W-1:0] wdata;
        logic [`WIN_DATA_W-1:0] rdata;
        logic done;
        logic fault;
        logic rst_n;
    } host_regs_type;

    typedef struct packed {
        logic [`TMR_W-1:0] cnt;
    } timer_regs_type;

    // least time in ns to whole clock cycles, never below one
    function automatic logic [`TMR_W-1:0] ns_to_cyc(input int ns);
        int c;
        c = (ns * `CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c[`TMR_W-1:0];
    endfunction : ns_to_cyc

endpackage : flash_host_pkg

// File: verilog/flash_host_timer.sv
// down counter that times every phase of the host sequencer
// assumes a load pulse from the sequencer on each phase entry
`include "flash_host_params.svh"

module flash_host_timer (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [`TMR_W-1:0] i_count,
    output logic o_last
);

    flash_host_pkg::timer_regs_type regs_r;
    flash_host_pkg::timer_regs_type regs_nxt;

    always_comb begin
        regs_nxt = regs_r;
        if (i_load) begin
            regs_nxt.cnt = i_count;
        end else if (regs_r.cnt != {`TMR_W{1'b0}}) begin
            regs_nxt.cnt = regs_r.cnt - {{(`TMR_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            regs_r <= '0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // loaded with n, last is seen in the n-th cycle after the load
    assign o_last = (regs_r.cnt <= {{(`TMR_W-1){1'b0}}, 1'b1});

endmodule : flash_host_timer

// File: verilog/end.sv
// intentionally empty

// File: tb/flash_dev_model.sv
// behavioural model of the flash disk device on the window pins
// assumes the bench pulls busy high and merges the data lines
`include "flash_host_params.svh"

module flash_dev_model #(
    parameter int LOAD_NS = 2000,
    parameter logic [1:0] SLOT_ID = 2'h0
) (
    input wire logic [`WIN_ADDR_W-1:0] i_addr,
    input wire logic [`WIN_DATA_W-1:0] i_data,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_reset_in_n,
    input wire logic [1:0] i_cascade_slot,
    input wire logic i_bad_copy,
    input wire logic i_stall,
    output logic [`WIN_DATA_W-1:0] o_data,
    output logic o_busy_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] boot [512];
    logic [7:0] page [4096];
    logic sel;
    logic drive;
    logic held;
    logic [11:0] poff;
    assign sel = !i_ce_n && i_cascade_slot == SLOT_ID && !o_busy_drive;
    assign poff = 12'(i_addr - 13'h0800);
    assign drive = sel && !i_oe_n;
    // one process owns the data lines; a released bus shows the
    // inverse of the last byte it carried
    initial begin
        o_data = 8'h00;
        held = 1'b0;
        forever begin
            @(drive or i_addr);
            if (drive) begin
                held = 1'b1;
                if (i_addr[12] == i_addr[11]) begin
                    o_data = boot[i_addr[8:0]];
                end else begin
                    o_data = page[poff];
                end
            end else if (held) begin
                held = 1'b0;
                o_data = ~o_data;
            end
        end
    end
    always @(posedge i_we_n) begin
        if (sel && i_addr[12] == i_addr[11]) begin
            boot[i_addr[8:0]] = i_data;
        end else if (sel) begin
            page[poff] = i_data;
        end
    end
    // busy falls with device reset; one load per reset release
    // however wide the window
    initial begin
        o_busy_drive = 1'b1;
        forever begin
            wait (i_reset_in_n === 1'b0);
            o_busy_drive = 1'b1;
            wait (i_reset_in_n === 1'b1);
            #(LOAD_NS);
            for (int i = 0; i < 512; i++) begin
                boot[i] = 8'(i) ^ (i_bad_copy ? 8'hA5 : 8'h3C)
                    ^ {7'h0, i[8]};
            end
            wait (!i_stall);
            if (i_reset_in_n) begin
                o_busy_drive = 1'b0;
            end
        end
    end
endmodule : flash_dev_model

// File: tb/test_flash_disk_host_window.sv
// self-checking bench for the flash disk host window controller
// assumes flash_dev_model stands on the device pins
`include "flash_host_params.svh"

module test_flash_disk_host_window;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk, i_rst_b, i_reinit, i_req_valid, o_req_ready, o_rsp_valid;
    logic o_init_fault, o_data_oe, o_ce_n, o_oe_n, o_we_n, o_reset_in_n;
    logic busy_drive, busy_n, bad_copy, stall;
    flash_host_pkg::host_req_type i_req;
    logic [7:0] o_rsp_data, o_data, dev_data, bus, q;
    logic [12:0] o_addr, a;
    logic [1:0] o_cascade_slot;
    logic [12:0] pa [8];
    logic [7:0] pd [8];
    int bad_count, comparisons, seed, i;
    // pull-up on the shared busy line
    assign busy_n = busy_drive ? 1'b0 : 1'b1;
    assign bus = o_data_oe ? o_data : dev_data;
    flash_disk_host_window #(.BOOT_TIMEOUT_CYC(50)) DUT (.i_mclk(i_mclk),
        .i_rst_b(i_rst_b), .i_reinit(i_reinit), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp_data(o_rsp_data), .o_init_fault(o_init_fault), .o_addr(o_addr),
        .i_data(bus), .o_data(o_data), .o_data_oe(o_data_oe), .o_ce_n(o_ce_n),
        .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_reset_in_n(o_reset_in_n),
        .o_cascade_slot(o_cascade_slot), .i_busy_n(busy_n));
    // load time kept off the clock grid so busy never ends on an edge
    flash_dev_model #(.LOAD_NS(2030)) dev (.i_addr(o_addr), .i_data(bus),
        .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_reset_in_n(o_reset_in_n), .i_cascade_slot(o_cascade_slot),
        .i_bad_copy(bad_copy), .i_stall(stall), .o_data(dev_data),
        .o_busy_drive(busy_drive));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    function automatic logic [7:0] boot_exp(logic [8:0] x, logic red);
        return x[7:0] ^ (red ? 8'hA5 : 8'h3C) ^ {7'h0, x[8]};
    endfunction : boot_exp
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic wait_for(input int which);
        int n;
        n = 0;
        while ((which == 0 ? o_req_ready : o_init_fault) !== 1'b1) begin
            @(posedge i_mclk);
            #1;
            n++;
            if (n > 300) begin
                check(1'b0, "wait ran out");
                final_report();
            end
        end
    endtask : wait_for
    task automatic access(input logic wr, input logic [12:0] ad,
            input logic [7:0] d, output logic [7:0] r);
        int n;
        i_req_valid = 1'b1;
        i_req = '{write: wr, addr: ad, wdata: d};
        wait_for(0);
        @(posedge i_mclk);
        #1;
        i_req_valid = 1'b0;
        n = 0;
        while (o_rsp_valid !== 1'b1 && n < 20) begin
            if (n == 2) begin
                check(o_ce_n === 1'b0 && o_addr === ad && (wr ? (o_we_n === 1'b0
                    && o_oe_n === 1'b1 && o_data_oe === 1'b1 && o_data === d)
                    : (o_oe_n === 1'b0 && o_we_n === 1'b1
                    && o_data_oe === 1'b0)), "strobe phase");
            end
            @(posedge i_mclk);
            #1;
            n++;
        end
        check(n == 4, "response latency");
        r = o_rsp_data;
    endtask : access
    task automatic reinit();
        // restart is only taken in idle, so let any access finish first
        wait_for(0);
        i_reinit = 1'b1;
        @(posedge i_mclk);
        #1;
        i_reinit = 1'b0;
        check(o_reset_in_n === 1'b0 && o_req_ready === 1'b0, "reinit");
    endtask : reinit
    // no access may start, with chip select falling, while the device is busy
    always @(negedge o_ce_n) begin
        check(busy_n === 1'b1, "access while busy");
    end
    initial begin
        seed = 32'hFCB60D95;
        {i_rst_b, i_reinit, i_req_valid, bad_copy, stall} = 5'h00;
        i_req = '0;
        repeat (8) @(posedge i_mclk);
        #1;
        check(o_reset_in_n === 1'b0 && busy_n === 1'b0, "reset hold");
        check(o_ce_n === 1'b1 && o_req_ready === 1'b0, "reset idle");
        check(o_cascade_slot === 2'h0, "slot strap");
        i_rst_b = 1'b1;
        wait_for(0);
        check(o_init_fault === 1'b0, "fault after reset");
        for (i = 0; i < 24; i++) begin
            a = 13'($random(seed));
            a[11] = a[12];
            if (i < 4) a = i[1] ? (i[0] ? 13'h1FFF : 13'h07FF) : {4'h0, i[0], 8'hFF};
            access(1'b0, a, 8'h00, q);
            check(q === boot_exp(a[8:0], 1'b0), "boot alias read");
        end
        for (i = 0; i < 8; i++) begin
            pa[i] = 13'h0800 + {1'b0, i[2:0], 9'h000} + 13'($random(seed) & 9'h1FF);
            pd[i] = 8'($random(seed));
            access(1'b1, pa[i], pd[i], q);
        end
        for (i = 0; i < 8; i++) begin
            access(1'b0, pa[i], 8'h00, q);
            check(q === pd[i], "page read back");
        end
        access(1'b1, 13'h0005, 8'hC3, q);
        access(1'b0, 13'h1A05, 8'h00, q);
        check(q === 8'hC3, "last region mirror");
        bad_copy = 1'b1;
        reinit();
        wait_for(0);
        access(1'b0, 13'h0110, 8'h00, q);
        check(q === boot_exp(9'h110, 1'b1), "redundant copy");
        stall = 1'b1;
        reinit();
        wait_for(1);
        check(o_req_ready === 1'b0, "ready while busy");
        stall = 1'b0;
        wait_for(0);
        reinit();
        wait_for(0);
        check(o_init_fault === 1'b0, "fault cleared");
        final_report();
    end
endmodule : test_flash_disk_host_window
